// [logic/afc_params.svh]
/*
  Register offsets, field positions, reset values and bus answers.
  Assumes inclusion by bare name.
*/
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define AFC_OFS_IF_LOW    8'h00
`define AFC_OFS_IF_HIGH   8'h04
`define AFC_OFS_CTRL      8'h08
`define AFC_OFS_CONFIG    8'h0c
`define AFC_OFS_STATUS    8'h10

// ************************************************************
// Field positions
// ************************************************************
`define AFC_BIT_RND_FWD   6
`define AFC_BIT_RND_REV   7
`define AFC_TRK_LO_MSB    15
`define AFC_TRK_LO_LSB    8
`define AFC_TRK_HI_MSB    7
`define AFC_TRK_HI_LSB    0
`define AFC_CB_DELETE     10
`define AFC_CB_EXT_ACK    11
`define AFC_CB_OP_ACK     12
`define AFC_CFG_MD_LOADED 0
`define AFC_CFG_HARD      1
`define AFC_ST_RND_EN     0
`define AFC_ST_RND_REV    1
`define AFC_ST_OP_ERR     2
`define AFC_ST_EXT_ERR    3
`define AFC_ST_APPR_OK    4
`define AFC_ST_OVERSHOOT  5
`define AFC_ST_PENDING    6

// ************************************************************
// Reset values and bus answers
// ************************************************************
`define AFC_RST_WORD      16'h0000
`define AFC_RST_TRACKS    16'h0000
`define AFC_RESP_OKAY     2'h0
`define AFC_RESP_SLVERR   2'h2

`endif

// [logic/afc_pkg.sv]
/*
  Types shared by the decoder files.
  Assumes afc_params.svh on the include path.
*/
package afc_pkg;

  // Decoded meaning of the two rounding bits
  typedef enum logic [1:0] {
    AFC_RQ_OFF,
    AFC_RQ_FWD,
    AFC_RQ_REV,
    AFC_RQ_BAD
  } afc_round_req_type;

endpackage : afc_pkg

// [logic/afc_ctrl_pulse.sv]
/*
  One-cycle pulse per control bit written as one.
  Assumes wr_i is high one cycle per accepted write.
*/
`timescale 1ns/10ps
module afc_ctrl_pulse #(
  parameter int W = 16
) (
  input  wire logic         wr_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic [1:0]   strb_i,
  output logic      [W-1:0] pulse_o
);

  // ************************************************************
  // Per-bit pulse
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      // A bit held set across writes fires again only on the next write
      assign pulse_o[g] = wr_i & strb_i[g / 8] & data_i[g]; // R16 R20
    end
  endgenerate

endmodule : afc_ctrl_pulse

// [logic/afc_rounding_calc.sv]
/*
  Rounding reversal offset and software-limit clearance check.
  Assumes all distances are unsigned and small enough not to overflow PW bits.
*/
`timescale 1ns/10ps
module afc_rounding_calc #(
  parameter int PW = 32
) (
  input  wire logic          hard_i,
  input  wire logic [PW-1:0] co_cpl_i,
  input  wire logic [PW-1:0] adp_co_cpl_i,
  input  wire logic [PW-1:0] co_trv_i,
  input  wire logic [PW-1:0] adp_co_trv_i,
  input  wire logic [PW-1:0] cut_trv_i,
  input  wire logic [PW-1:0] adp_cut_trv_i,
  input  wire logic [PW-1:0] zero_rng_i,
  input  wire logic [PW-1:0] limit_dist_i,
  output logic      [PW-1:0] offset_o,
  output logic               ok_o
);

  logic [PW-1:0] cpl_part;
  logic [PW-1:0] trv_part;
  logic [PW-1:0] need;

  // ************************************************************
  // Offset and clearance
  // ************************************************************
  assign cpl_part = co_cpl_i + adp_co_cpl_i; // R6
  // Hard reversal must brake over a full changeover in travel direction
  assign trv_part = hard_i ? (co_trv_i + adp_co_trv_i) : (cut_trv_i + adp_cut_trv_i); // R5 R6
  assign offset_o = cpl_part + trv_part; // R6
  assign need     = offset_o + zero_rng_i; // R11 R12
  assign ok_o     = (limit_dist_i >= need); // R11 R12

endmodule : afc_rounding_calc

// [logic/afc_axis_function_control_decoder.sv]
/*
  Per-axis decoder of the function words and control-bit word over AXI4-Lite;
  drives rounding, track enables, delete and acknowledges.
  Assumes one clock, synchronous inputs and a motion block that acts on the
  outputs and supplies axis status and the external-error cause.
*/
// Behaviour
// R1: Bit 6 alone selects forward coupling, bit 7 alone reverse coupling.
// R2: Both rounding bits set raises an operator error, rounding unchanged.
// R3: Rounding changes take effect only while axis is completed or interrupted.
// R4: With rounding on, approach targets in coupling direction, overshooting if needed.
// R5: Reversal is hard or soft as machine data selects.
// R6: Reversal point comes from changeover and cutoff differences plus adaption.
// R7: During rounding adaption updates only coupling-direction differences.
// R8: Both bits clear turns rounding off; actual position untouched.
// R9: Rounding inactive without machine data and after restart.
// R10: Active rounding stays on when coupling is lost.
// R11: Soft rounding needs limit distance of coupling changeover, cutoff, zero range.
// R12: Hard rounding needs limit distance of both changeovers plus zero range.
// R13: Tracks 1-16 map to low word bits 8-15 then high word bits 0-7.
// R14: Track enabled while its bit set, whether or not parameterized.
// R15: All tracks off without machine data, after restart, on external error.
// R16: A control-bit function runs when its bit is set in the control word.
// R17: Control bit 10 discards all pending position or event dependent changes.
// R18: Control bit 11 clears external error only if its cause has gone.
// R19: Control bit 12 clears the pending operator error.
// R20: Each control-bit function runs once per write that sets its bit.
`timescale 1ns/10ps
`include "afc_params.svh"
module afc_axis_function_control_decoder #(
  parameter int PW = 32
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // AXI4-Lite slave
  input  wire logic [7:0]    s_axi_awaddr_i,
  input  wire logic          s_axi_awvalid_i,
  output logic               s_axi_awready_o,
  input  wire logic [31:0]   s_axi_wdata_i,
  input  wire logic [3:0]    s_axi_wstrb_i,
  input  wire logic          s_axi_wvalid_i,
  output logic               s_axi_wready_o,
  output logic [1:0]         s_axi_bresp_o,
  output logic               s_axi_bvalid_o,
  input  wire logic          s_axi_bready_i,
  input  wire logic [7:0]    s_axi_araddr_i,
  input  wire logic          s_axi_arvalid_i,
  output logic               s_axi_arready_o,
  output logic [31:0]        s_axi_rdata_o,
  output logic [1:0]         s_axi_rresp_o,
  output logic               s_axi_rvalid_o,
  input  wire logic          s_axi_rready_i,
  // Axis side
  input  wire logic          restart_i,
  input  wire logic          axis_idle_i,
  input  wire logic          ext_err_event_i,
  input  wire logic          ext_err_cause_i,
  input  wire logic [PW-1:0] target_i,
  input  wire logic [PW-1:0] actual_i,
  input  wire logic [PW-1:0] co_cpl_i,
  input  wire logic [PW-1:0] adp_co_cpl_i,
  input  wire logic [PW-1:0] co_trv_i,
  input  wire logic [PW-1:0] adp_co_trv_i,
  input  wire logic [PW-1:0] cut_trv_i,
  input  wire logic [PW-1:0] adp_cut_trv_i,
  input  wire logic [PW-1:0] zero_rng_i,
  input  wire logic [PW-1:0] limit_dist_i,
  output logic               round_en_o,
  output logic               round_rev_o,
  output logic               round_hard_o,
  output logic               overshoot_o,
  output logic [PW-1:0]      rev_point_o,
  output logic               approach_ok_o,
  output logic               adapt_cpl_only_o,
  output logic [15:0]        track_en_o,
  output logic               delete_pend_o,
  output logic               ext_err_o,
  output logic               op_err_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic          aw_have;
    logic [7:0]    aw_addr;
    logic          w_have;
    logic [15:0]   w_data;
    logic [1:0]    w_strb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic [15:0]   if_low;
    logic [15:0]   if_high;
    logic [15:0]   ctrl;
    logic          md_loaded;
    logic          hard_rev;
    logic          apply_pend;
    logic          round_en;
    logic          round_rev;
    logic          op_err;
    logic          ext_err;
    logic [15:0]   track_en;
    logic          overshoot;
    logic [PW-1:0] rev_point;
    logic          approach_ok;
    logic          delete_pend;
  } afc_state_type;

  afc_state_type s;
  afc_state_type next_s;

  logic                       wr_go;
  logic [15:0]                cb_pulse;
  logic [PW-1:0]              rnd_offset;
  logic                       rnd_ok;
  afc_pkg::afc_round_req_type rq;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic afc_mapped(input logic [7:0] a);
    afc_mapped = (a == `AFC_OFS_IF_LOW) || (a == `AFC_OFS_IF_HIGH) || (a == `AFC_OFS_CTRL) ||
                 (a == `AFC_OFS_CONFIG) || (a == `AFC_OFS_STATUS);
  endfunction : afc_mapped

  function automatic logic [15:0] afc_merge(input logic [15:0] old, input logic [15:0] d,
                                            input logic [1:0] st);
    afc_merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction : afc_merge

  function automatic afc_pkg::afc_round_req_type afc_decode_round(input logic [15:0] w);
    case ({w[`AFC_BIT_RND_REV], w[`AFC_BIT_RND_FWD]}) // R1
      2'h1:    afc_decode_round = afc_pkg::AFC_RQ_FWD;
      2'h2:    afc_decode_round = afc_pkg::AFC_RQ_REV;
      2'h3:    afc_decode_round = afc_pkg::AFC_RQ_BAD;
      default: afc_decode_round = afc_pkg::AFC_RQ_OFF;
    endcase
  endfunction : afc_decode_round

  // ************************************************************
  // Sub-blocks
  // ************************************************************
  assign wr_go = s.aw_have & s.w_have & ~s.bvalid;

  afc_ctrl_pulse #(
    .W (16)
  ) u_pulse (
    .wr_i    (wr_go && (s.aw_addr == `AFC_OFS_CTRL)),
    .data_i  (s.w_data),
    .strb_i  (s.w_strb),
    .pulse_o (cb_pulse)
  );

  afc_rounding_calc #(
    .PW (PW)
  ) u_calc (
    .hard_i        (s.hard_rev),
    .co_cpl_i      (co_cpl_i),
    .adp_co_cpl_i  (adp_co_cpl_i),
    .co_trv_i      (co_trv_i),
    .adp_co_trv_i  (adp_co_trv_i),
    .cut_trv_i     (cut_trv_i),
    .adp_cut_trv_i (adp_cut_trv_i),
    .zero_rng_i    (zero_rng_i),
    .limit_dist_i  (limit_dist_i),
    .offset_o      (rnd_offset),
    .ok_o          (rnd_ok)
  );

  assign rq = afc_decode_round(s.if_low);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_s = s;
    next_s.delete_pend = 1'b0;

    // Write address and data are taken independently
    if (s_axi_awvalid_i && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.w_data = s_axi_wdata_i[15:0];
      next_s.w_strb = s_axi_wstrb_i[1:0];
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = afc_mapped(s.aw_addr) ? `AFC_RESP_OKAY : `AFC_RESP_SLVERR;
      case (s.aw_addr)
        `AFC_OFS_IF_LOW: begin
          next_s.if_low = afc_merge(s.if_low, s.w_data, s.w_strb);
          // Rounding bits sit in the low byte
          if (s.w_strb[0]) begin
            next_s.apply_pend = 1'b1;
          end
        end
        `AFC_OFS_IF_HIGH: begin
          next_s.if_high = afc_merge(s.if_high, s.w_data, s.w_strb);
        end
        `AFC_OFS_CTRL: begin
          next_s.ctrl = afc_merge(s.ctrl, s.w_data, s.w_strb);
        end
        `AFC_OFS_CONFIG: begin
          if (s.w_strb[0]) begin
            next_s.md_loaded = s.w_data[`AFC_CFG_MD_LOADED];
            next_s.hard_rev  = s.w_data[`AFC_CFG_HARD]; // R5
          end
        end
        default: begin
        end
      endcase
    end
    next_s.awready = ~next_s.aw_have & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_have & ~next_s.bvalid;

    // Read channel
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = afc_mapped(s_axi_araddr_i) ? `AFC_RESP_OKAY : `AFC_RESP_SLVERR;
      next_s.rdata  = 32'h0;
      case (s_axi_araddr_i)
        `AFC_OFS_IF_LOW:  next_s.rdata[15:0] = s.if_low;
        `AFC_OFS_IF_HIGH: next_s.rdata[15:0] = s.if_high;
        `AFC_OFS_CTRL:    next_s.rdata[15:0] = s.ctrl;
        `AFC_OFS_CONFIG: begin
          next_s.rdata[`AFC_CFG_MD_LOADED] = s.md_loaded;
          next_s.rdata[`AFC_CFG_HARD]      = s.hard_rev;
        end
        `AFC_OFS_STATUS: begin
          next_s.rdata[`AFC_ST_RND_EN]    = s.round_en;
          next_s.rdata[`AFC_ST_RND_REV]   = s.round_rev;
          next_s.rdata[`AFC_ST_OP_ERR]    = s.op_err;
          next_s.rdata[`AFC_ST_EXT_ERR]   = s.ext_err;
          next_s.rdata[`AFC_ST_APPR_OK]   = s.approach_ok;
          next_s.rdata[`AFC_ST_OVERSHOOT] = s.overshoot;
          next_s.rdata[`AFC_ST_PENDING]   = s.apply_pend;
        end
        default: begin
        end
      endcase
    end
    next_s.arready = ~next_s.rvalid;

    // Control-bit functions, one shot per write
    next_s.delete_pend = cb_pulse[`AFC_CB_DELETE]; // R17
    if (cb_pulse[`AFC_CB_OP_ACK]) begin
      next_s.op_err = 1'b0; // R19
    end
    if (cb_pulse[`AFC_CB_EXT_ACK] && !ext_err_cause_i) begin
      next_s.ext_err = 1'b0; // R18
    end
    // A new error in the acknowledge cycle survives it
    if (ext_err_event_i) begin
      next_s.ext_err = 1'b1;
    end

    // Rounding change waits for a quiet axis; coupling loss is not an input
    if (s.apply_pend && axis_idle_i) begin // R3 R10
      next_s.apply_pend = 1'b0;
      case (rq)
        afc_pkg::AFC_RQ_FWD: begin
          next_s.round_en  = 1'b1; // R1
          next_s.round_rev = 1'b0;
        end
        afc_pkg::AFC_RQ_REV: begin
          next_s.round_en  = 1'b1; // R1
          next_s.round_rev = 1'b1;
        end
        afc_pkg::AFC_RQ_BAD: begin
          next_s.op_err = 1'b1; // R2
        end
        default: begin
          next_s.round_en = 1'b0; // R8
        end
      endcase
    end

    // Restart clears the function words
    if (restart_i) begin
      next_s.if_low     = `AFC_RST_WORD;
      next_s.if_high    = `AFC_RST_WORD;
      next_s.apply_pend = 1'b0;
    end
    if (restart_i || !next_s.md_loaded) begin
      next_s.round_en = 1'b0; // R9
    end

    // Tracks follow their bits directly, parameterized or not
    if (next_s.md_loaded && !next_s.ext_err && !restart_i) begin
      next_s.track_en = {next_s.if_high[`AFC_TRK_HI_MSB:`AFC_TRK_HI_LSB],
                         next_s.if_low[`AFC_TRK_LO_MSB:`AFC_TRK_LO_LSB]}; // R13 R14
    end else begin
      next_s.track_en = `AFC_RST_TRACKS; // R15
    end

    // Target behind the coupling direction forces an overshoot and reversal
    next_s.overshoot = s.round_en &&
                       (s.round_rev ? ($signed(target_i) > $signed(actual_i))
                                    : ($signed(target_i) < $signed(actual_i))); // R4
    next_s.rev_point = s.round_rev ? (target_i + rnd_offset) : (target_i - rnd_offset); // R4 R6
    next_s.approach_ok = ~s.round_en | rnd_ok; // R11 R12
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign s_axi_awready_o  = s.awready;
  assign s_axi_wready_o   = s.wready;
  assign s_axi_bresp_o    = s.bresp;
  assign s_axi_bvalid_o   = s.bvalid;
  assign s_axi_arready_o  = s.arready;
  assign s_axi_rdata_o    = s.rdata;
  assign s_axi_rresp_o    = s.rresp;
  assign s_axi_rvalid_o   = s.rvalid;
  // Position is never written here, so switching rounding cannot move it
  assign round_en_o       = s.round_en; // R8
  assign round_rev_o      = s.round_rev;
  assign round_hard_o     = s.hard_rev; // R5
  assign overshoot_o      = s.overshoot;
  assign rev_point_o      = s.rev_point;
  assign approach_ok_o    = s.approach_ok;
  assign adapt_cpl_only_o = s.round_en; // R7
  assign track_en_o       = s.track_en;
  assign delete_pend_o    = s.delete_pend;
  assign ext_err_o        = s.ext_err;
  assign op_err_o         = s.op_err;

endmodule : afc_axis_function_control_decoder

// [dv/afc_dec_checker.sv]
/*
  Port assertions for the decoder.
  Assumes binding to the decoder top.
*/
`timescale 1ns/10ps
module afc_dec_checker (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        restart_i,
  input wire logic        ext_err_event_i,
  input wire logic        ext_err_cause_i,
  input wire logic        round_en_o,
  input wire logic        adapt_cpl_only_o,
  input wire logic [15:0] track_en_o,
  input wire logic        delete_pend_o,
  input wire logic        ext_err_o
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_bvalid_holds:
    assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("bvalid dropped");
  a_rvalid_holds:
    assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
      else $error("rvalid dropped");
  a_read_blocked:
    assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("second read accepted");
  a_delete_single:
    assert property (delete_pend_o |=> !delete_pend_o)
      else $error("delete pulse too long");
  a_delete_cause:
    assert property ($rose(delete_pend_o) |-> $rose(s_axi_bvalid_o))
      else $error("delete without write");
  a_ext_err_set:
    assert property (ext_err_event_i |=> ext_err_o)
      else $error("ext error not set");
  a_ext_err_keep:
    assert property (ext_err_o && ext_err_cause_i && !restart_i |=> ext_err_o)
      else $error("ext error cleared with cause");
  a_track_err_off:
    assert property (ext_err_o |-> track_en_o == 16'h0000)
      else $error("tracks on during ext error");
  a_track_restart:
    assert property (restart_i |=> track_en_o == 16'h0000)
      else $error("tracks on after restart");
  a_round_restart:
    assert property (restart_i |=> !round_en_o)
      else $error("rounding on after restart");
  a_adapt_follow:
    assert property (adapt_cpl_only_o == round_en_o)
      else $error("adaption select wrong");
endmodule : afc_dec_checker

bind afc_axis_function_control_decoder afc_dec_checker afc_dec_checker_inst (.*);

// [dv/afc_plc_model.sv]
/*
  AXI4-Lite master standing in for the controller.
  Assumes one task at a time; waits are bounded.
*/
`timescale 1ns/10ps
module afc_plc_model (
  input  wire logic        clk_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  input  wire logic        awready_i,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic             rready_o
);
  // ************************************************************
  // Bus cycles
  // ************************************************************
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end

  // Released payload is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s,
                    output logic [1:0] r, output bit ok);
    ok = 0;
    r = 2'h3;
    @(posedge clk_i);
    {awaddr_o, awvalid_o, wvalid_o, bready_o} <= {a, 3'h7};
    {wdata_o, wstrb_o} <= {16'h0000, d, 2'h0, s};
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge clk_i);
      if (awready_i) {awaddr_o, awvalid_o} <= {~a, 1'b0};
      if (wready_i) {wdata_o, wvalid_o} <= {16'hffff, ~d, 1'b0};
      if (bvalid_i) begin
        r = bresp_i;
        ok = 1;
        bready_o <= 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit ok);
    ok = 0;
    {d, r} = '1;
    @(posedge clk_i);
    {araddr_o, arvalid_o, rready_o} <= {a, 2'h3};
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge clk_i);
      if (arready_i) {araddr_o, arvalid_o} <= {~a, 1'b0};
      if (rvalid_i) begin
        {d, r} = {rdata_i, rresp_i};
        ok = 1;
        rready_o <= 1'b0;
      end
    end
  endtask : rd
endmodule : afc_plc_model

// [dv/axis_function_control_decoder_tb_top.sv]
/*
  Self-checking bench of the decoder.
  Assumes the controller model drives the bus.
*/
`timescale 1ns/10ps
`include "afc_params.svh"
module axis_function_control_decoder_tb_top;
  logic        clk_i = 0, rst_n_i = 0, restart_i = 0, axis_idle_i = 0;
  logic        ext_err_event_i = 0, ext_err_cause_i = 0;
  logic [31:0] pv [10] = '{default: '0};
  logic [31:0] seed = 32'h0000bb6b;
  int          n_mismatch = 0, n_tests = 0, n_del = 0;
  wire [7:0]   s_axi_awaddr_i, s_axi_araddr_i;
  wire [31:0]  s_axi_wdata_i, s_axi_rdata_o, rev_point_o;
  wire [3:0]   s_axi_wstrb_i;
  wire [1:0]   s_axi_bresp_o, s_axi_rresp_o;
  wire [15:0]  track_en_o;
  wire         s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  wire         s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  wire         s_axi_rvalid_o, s_axi_rready_i, round_en_o, round_rev_o, round_hard_o;
  wire         overshoot_o, approach_ok_o, adapt_cpl_only_o, delete_pend_o;
  wire         ext_err_o, op_err_o;

  afc_axis_function_control_decoder afc_axis_function_control_decoder_inst (
    .*, .target_i(pv[0]), .actual_i(pv[1]), .co_cpl_i(pv[2]), .adp_co_cpl_i(pv[3]),
    .co_trv_i(pv[4]), .adp_co_trv_i(pv[5]), .cut_trv_i(pv[6]), .adp_cut_trv_i(pv[7]),
    .zero_rng_i(pv[8]), .limit_dist_i(pv[9])
  );

  afc_plc_model afc_plc_model_inst (
    .clk_i, .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
    .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
    .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
    .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
    .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (delete_pend_o === 1'b1) n_del++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [31:0] exp_off(logic h);
    return pv[2] + pv[3] + (h ? pv[4] + pv[5] : pv[6] + pv[7]);
  endfunction : exp_off

  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    bit         ok;
    afc_plc_model_inst.wr(a, d, 2'h3, r, ok);
    chk("bresp", {29'h0, ok, r}, {29'h1, er});
    if (!ok) close_out();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    bit          ok;
    afc_plc_model_inst.rd(a, d, r, ok);
    chk("rresp", {29'h0, ok, r}, {29'h1, er});
    chk("rdata", d, {16'h0000, ed});
    if (!ok) close_out();
  endtask : rd

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    logic [15:0] lo, hi;
    logic [1:0]  c;
    logic        h;
    logic [31:0] off;
    int          d0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(2);
    for (int i = 0; i < 4; i++) rd(8'(i * 4), 16'h0000);
    rd(8'h20, 16'h0000, `AFC_RESP_SLVERR);
    wr(8'h20, 16'hffff, `AFC_RESP_SLVERR);
    wr(`AFC_OFS_IF_HIGH, 16'h00ff);
    chk("trk_nomd", 32'(track_en_o), 32'h0);
    wr(`AFC_OFS_CONFIG, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      {hi, lo} = xs() & 32'hffffff3f;
      wr(`AFC_OFS_IF_LOW, lo);
      wr(`AFC_OFS_IF_HIGH, hi);
      chk("tracks", 32'(track_en_o), {16'h0, hi[7:0], lo[15:8]});
      rd(`AFC_OFS_IF_HIGH, hi);
    end
    {ext_err_cause_i, ext_err_event_i} <= 2'h3;
    cyc(1);
    ext_err_event_i <= 1'b0;
    cyc(2);
    chk("ext_err", 32'(ext_err_o), 32'h1);
    chk("trk_err", 32'(track_en_o), 32'h0);
    wr(`AFC_OFS_CTRL, 16'h0800);
    cyc(2);
    chk("ext_kept", 32'(ext_err_o), 32'h1);
    ext_err_cause_i <= 1'b0;
    wr(`AFC_OFS_CTRL, 16'h0800);
    cyc(2);
    chk("ext_ack", 32'(ext_err_o), 32'h0);
    for (int i = 0; i < 2; i++) begin
      d0 = n_del;
      wr(`AFC_OFS_CTRL, 16'h0400);
      cyc(8);
      chk("del_once", 32'(n_del - d0), 32'h1);
    end
    wr(`AFC_OFS_IF_LOW, 16'h0040);
    cyc(4);
    chk("rnd_busy", 32'(round_en_o), 32'h0);
    axis_idle_i <= 1'b1;
    cyc(3);
    chk("rnd_idle", 32'(round_en_o), 32'h1);
    for (int i = 0; i < 8; i++) begin
      c = 2'(i + 1);
      h = i[2];
      wr(`AFC_OFS_CONFIG, {14'h0000, h, 1'b1});
      for (int j = 0; j < 9; j++) pv[j] <= xs() & 32'h0000ffff;
      pv[9] <= xs() & 32'h0003ffff;
      wr(`AFC_OFS_IF_LOW, {8'h00, c, 6'h00});
      cyc(3);
      chk("hard", 32'(round_hard_o), 32'(h));
      if (c == 2'h3) begin
        chk("op_err", 32'(op_err_o), 32'h1);
        chk("rnd_keep", 32'(round_en_o), 32'h1);
        wr(`AFC_OFS_CTRL, 16'h1000);
        cyc(3);
        chk("op_ack", 32'(op_err_o), 32'h0);
      end else begin
        chk("rnd_en", 32'(round_en_o), 32'(c != 2'h0));
        chk("adapt", 32'(adapt_cpl_only_o), 32'(c != 2'h0));
      end
      if (c == 2'h1 || c == 2'h2) begin
        off = exp_off(h);
        chk("rnd_dir", 32'(round_rev_o), 32'(c[1]));
        chk("rev_pt", rev_point_o, c[1] ? pv[0] + off : pv[0] - off);
        chk("appr_ok", 32'(approach_ok_o), 32'(pv[9] >= off + pv[8]));
        chk("oversh", 32'(overshoot_o), 32'(c[1] ? pv[0] > pv[1] : pv[0] < pv[1]));
      end
    end
    wr(`AFC_OFS_IF_LOW, 16'h5540);
    wr(`AFC_OFS_IF_HIGH, 16'h00aa);
    cyc(3);
    restart_i <= 1'b1;
    cyc(1);
    restart_i <= 1'b0;
    cyc(2);
    chk("rst_rnd", 32'(round_en_o), 32'h0);
    chk("rst_trk", 32'(track_en_o), 32'h0);
    rd(`AFC_OFS_IF_LOW, 16'h0000);
    close_out();
  end
endmodule : axis_function_control_decoder_tb_top
